// >>> hw/omm_defs.vh
// Constants for the optical module management port.
`ifndef OMM_DEFS_VH
`define OMM_DEFS_VH
// ==========================================================================
// Serial bus addressing
`define OMM_DEV_ADDR 7'h50
`define OMM_MEM_AW 8
// ==========================================================================
// Diagnostic map locations
`define OMM_LOC_TEMP 8'h60
`define OMM_LOC_BIAS 8'h61
`define OMM_LOC_TXPWR 8'h62
`define OMM_LOC_RXPWR 8'h63
`define OMM_LOC_VCC 8'h64
`define OMM_LOC_ALARM 8'h65
`define OMM_LOC_WARN 8'h66
`define OMM_LOC_STATUS 8'h67
// Locations below this address are write-protected.
`define OMM_WP_TOP 8'h80
// Alarm/warning limits, factory values.
`define OMM_ALARM_HI 8'hF0
`define OMM_ALARM_LO 8'h08
`define OMM_WARN_HI 8'hE0
`define OMM_WARN_LO 8'h10
// ==========================================================================
// Timing
`define OMM_CLK_NS 100
`define OMM_LASER_OFF_US 10
`define OMM_LASER_OFF_CYC ((`OMM_LASER_OFF_US * 1000) / `OMM_CLK_NS)
`define OMM_INIT_CYC 16
`endif

// >>> hw/omm_sync.v
// Three-stage input synchroniser with agreement of the last two stages.
`timescale 1ns/1ps
module omm_sync #(
    parameter RESET_VAL = 1'b1
) (
    clock,
    rst_b,
    din,
    dout
);
    input wire clock;
    input wire rst_b;
    input wire din;
    output reg dout;
    reg s1_r;
    reg s2_r;
    reg s3_r;
    // ======================================================================
    // Stages; the first stage feeds only the second to contain metastability.
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            s1_r <= RESET_VAL;
            s2_r <= RESET_VAL;
            s3_r <= RESET_VAL;
            dout <= RESET_VAL;
        end else begin
            s1_r <= din;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r) begin
                dout <= s3_r;
            end
        end
    end
endmodule

// >>> hw/omm_mgmt_port.v
// Management side of the optical module: pins, serial memory and diagnostics.
// Function
// - Serial commands honoured only while select is low.
// - Interrupt low on condition, cause readable serially.
// - Laser off within 10 us of request.
// - Signal-lost pin 0 normal, 1 no light.
// - Module-absent pin tied low inside module.
// - Power-down high holds low-power standby.
// - Power-down falling edge resets bus state and init timer; memory kept.
// - Status and serial lines open-drain only.
// - Write sampled on rising clock, unprotected only.
// - Read data changes on falling clock.
// - Byte words, random or sequential access.
// - Addresses run contiguously from zero.
// - Diagnostic values continuously refreshed.
// - Alarm and warning flags outside normal range.
`timescale 1ns/1ps
`include "omm_defs.vh"
module omm_mgmt_port #(
    parameter AW = `OMM_MEM_AW,
    parameter INIT_CYC = `OMM_INIT_CYC
) (
    clock,
    rst_b,
    mod_desel,
    laser_off_request,
    power_down,
    scl,
    sda_in,
    sda_oe,
    sda_out,
    rx_light_ok,
    temp_adc,
    bias_adc,
    txpwr_adc,
    rxpwr_adc,
    vcc_adc,
    laser_enable,
    low_power,
    mod_abs_oe,
    mod_abs_out,
    module_not_ready_flag_oe,
    module_not_ready_flag_out,
    interrupt_oe,
    interrupt_out,
    receive_signal_lost_oe,
    receive_signal_lost_out
);
    input wire clock;
    input wire rst_b;
    input wire mod_desel;
    input wire laser_off_request;
    input wire power_down;
    input wire scl;
    input wire sda_in;
    output reg sda_oe;
    output reg sda_out;
    input wire rx_light_ok;
    input wire [7:0] temp_adc;
    input wire [7:0] bias_adc;
    input wire [7:0] txpwr_adc;
    input wire [7:0] rxpwr_adc;
    input wire [7:0] vcc_adc;
    output reg laser_enable;
    output reg low_power;
    output reg mod_abs_oe;
    output reg mod_abs_out;
    output reg module_not_ready_flag_oe;
    output reg module_not_ready_flag_out;
    output reg interrupt_oe;
    output reg interrupt_out;
    output reg receive_signal_lost_oe;
    output reg receive_signal_lost_out;

    localparam ST_IDLE = 3'd0;
    localparam ST_DEVA = 3'd1;
    localparam ST_WADR = 3'd2;
    localparam ST_WDAT = 3'd3;
    localparam ST_RDAT = 3'd4;
    localparam ST_RACK = 3'd5;
    localparam ST_SKIP = 3'd6;

    wire scl_s;
    wire sda_s;
    wire desel_s;
    wire loff_s;
    wire pdn_s;
    wire los_s;
    reg scl_d_r;
    reg sda_d_r;
    reg pdn_d_r;
    reg soft_rst_r;
    reg [2:0] st_r;
    reg [3:0] bit_r;
    reg [7:0] sh_r;
    reg [AW-1:0] adr_r;
    reg [7:0] mem [0:(1<<AW)-1];
    reg [7:0] alarm_r;
    reg [7:0] warn_r;
    reg [15:0] init_cnt_r;
    reg ready_r;
    integer i;

    // ======================================================================
    // Pin synchronisers; every single-bit input except clock and reset passes three stages; the ADC buses are not synchronised.
    omm_sync #(.RESET_VAL(1'b1)) u_scl (.clock(clock), .rst_b(rst_b), .din(scl), .dout(scl_s));
    omm_sync #(.RESET_VAL(1'b1)) u_sda (.clock(clock), .rst_b(rst_b), .din(sda_in), .dout(sda_s));
    omm_sync #(.RESET_VAL(1'b1)) u_des (.clock(clock), .rst_b(rst_b), .din(mod_desel), .dout(desel_s));
    omm_sync #(.RESET_VAL(1'b1)) u_lof (.clock(clock), .rst_b(rst_b), .din(laser_off_request), .dout(loff_s));
    omm_sync #(.RESET_VAL(1'b1)) u_pdn (.clock(clock), .rst_b(rst_b), .din(power_down), .dout(pdn_s));
    omm_sync #(.RESET_VAL(1'b0)) u_los (.clock(clock), .rst_b(rst_b), .din(rx_light_ok), .dout(los_s));

    wire scl_rise = scl_s & ~scl_d_r;
    wire scl_fall = ~scl_s & scl_d_r;
    wire start_c = scl_s & scl_d_r & sda_d_r & ~sda_s;
    wire stop_c = scl_s & scl_d_r & ~sda_d_r & sda_s;

    // Range check used for both alarm and warning bands.
    function out_of;
        input [7:0] v;
        input [7:0] lo;
        input [7:0] hi;
        begin
            out_of = (v < lo) || (v > hi);
        end
    endfunction

    // ======================================================================
    // Edge history and the power-down falling-edge reset pulse.
    // The pulse is a synchronous reset of the bus state machine, init timer and laser;
    // memory and flags keep their values, and the asynchronous reset net is not gated.
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
            pdn_d_r <= 1'b1;
            soft_rst_r <= 1'b0;
        end else begin
            scl_d_r <= scl_s;
            sda_d_r <= sda_s;
            pdn_d_r <= pdn_s;
            soft_rst_r <= pdn_d_r & ~pdn_s;
        end
    end

    // ======================================================================
    // Initialisation timer, standby and laser control.
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            init_cnt_r <= 16'h0000;
            ready_r <= 1'b0;
            laser_enable <= 1'b0;
            low_power <= 1'b1;
        end else if (soft_rst_r) begin
            init_cnt_r <= 16'h0000;
            ready_r <= 1'b0;
            laser_enable <= 1'b0;
            low_power <= 1'b0;
        end else begin
            low_power <= pdn_s;
            if (pdn_s) begin
                ready_r <= 1'b0;
                init_cnt_r <= 16'h0000;
            end else if (init_cnt_r == INIT_CYC[15:0]) begin
                ready_r <= 1'b1;
            end else begin
                init_cnt_r <= init_cnt_r + 16'h0001;
            end
            // The request reaches the laser five cycles after the pin moves, far inside the limit.
            laser_enable <= ready_r & ~pdn_s & ~loff_s;
        end
    end

    // ======================================================================
    // Two-wire slave state machine with memory array.
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            st_r <= ST_IDLE;
            bit_r <= 4'h0;
            sh_r <= 8'h00;
            adr_r <= {AW{1'b0}};
            sda_oe <= 1'b0;
            sda_out <= 1'b0;
            alarm_r <= 8'h00;
            warn_r <= 8'h00;
            for (i = 0; i < (1<<AW); i = i + 1) begin
                mem[i] <= 8'h00;
            end
        end else if (soft_rst_r) begin
            st_r <= ST_IDLE;
            bit_r <= 4'h0;
            adr_r <= {AW{1'b0}};
            sda_oe <= 1'b0;
            sda_out <= 1'b0;
        end else begin
            // Diagnostics refresh every cycle; the host sees the latest.
            mem[`OMM_LOC_TEMP] <= temp_adc;
            mem[`OMM_LOC_BIAS] <= bias_adc;
            mem[`OMM_LOC_TXPWR] <= txpwr_adc;
            mem[`OMM_LOC_RXPWR] <= rxpwr_adc;
            mem[`OMM_LOC_VCC] <= vcc_adc;
            alarm_r <= {3'h0, out_of(vcc_adc, `OMM_ALARM_LO, `OMM_ALARM_HI),
                out_of(rxpwr_adc, `OMM_ALARM_LO, `OMM_ALARM_HI),
                out_of(txpwr_adc, `OMM_ALARM_LO, `OMM_ALARM_HI),
                out_of(bias_adc, `OMM_ALARM_LO, `OMM_ALARM_HI),
                out_of(temp_adc, `OMM_ALARM_LO, `OMM_ALARM_HI)};
            warn_r <= {3'h0, out_of(vcc_adc, `OMM_WARN_LO, `OMM_WARN_HI),
                out_of(rxpwr_adc, `OMM_WARN_LO, `OMM_WARN_HI),
                out_of(txpwr_adc, `OMM_WARN_LO, `OMM_WARN_HI),
                out_of(bias_adc, `OMM_WARN_LO, `OMM_WARN_HI),
                out_of(temp_adc, `OMM_WARN_LO, `OMM_WARN_HI)};
            mem[`OMM_LOC_ALARM] <= alarm_r;
            mem[`OMM_LOC_WARN] <= warn_r;
            mem[`OMM_LOC_STATUS] <= {5'h00, ~los_s, ~laser_enable, ~ready_r};
            if (desel_s) begin
                st_r <= ST_IDLE;
                sda_oe <= 1'b0;
                bit_r <= 4'h0;
            end else if (start_c) begin
                st_r <= ST_DEVA;
                bit_r <= 4'h0;
                sda_oe <= 1'b0;
            end else if (stop_c) begin
                st_r <= ST_IDLE;
                sda_oe <= 1'b0;
            end else if (scl_rise && st_r != ST_IDLE) begin
                // Rising edge: take a data bit or the host's acknowledge.
                if (bit_r < 4'h8) begin
                    sh_r <= {sh_r[6:0], sda_s};
                    bit_r <= bit_r + 4'h1;
                end else begin
                    bit_r <= 4'h0;
                    if (st_r == ST_RDAT) begin
                        // A released line in the acknowledge slot ends the read.
                        if (sda_s) begin
                            st_r <= ST_SKIP;
                        end
                    end else if (st_r == ST_DEVA) begin
                        if (sh_r[7:1] != `OMM_DEV_ADDR) begin
                            st_r <= ST_SKIP;
                        end else if (sh_r[0]) begin
                            st_r <= ST_RDAT;
                        end else begin
                            st_r <= ST_WADR;
                        end
                    end else if (st_r == ST_WADR) begin
                        adr_r <= sh_r[AW-1:0];
                        st_r <= ST_WDAT;
                    end else if (st_r == ST_WDAT) begin
                        if (adr_r >= `OMM_WP_TOP) begin
                            mem[adr_r] <= sh_r;
                        end
                        adr_r <= adr_r + {{(AW-1){1'b0}}, 1'b1};
                    end
                end
            end else if (scl_fall && st_r != ST_IDLE && st_r != ST_SKIP) begin
                // Falling edge: the only edge on which the module pulls SDA low; start, stop and deselect just release it.
                if (bit_r == 4'h8 && st_r != ST_RDAT && (st_r != ST_DEVA || sh_r[7:1] == `OMM_DEV_ADDR)) begin
                    sda_oe <= 1'b1;
                    sda_out <= 1'b0;
                end else if (st_r == ST_RDAT && bit_r < 4'h8) begin
                    if (bit_r == 4'h0) begin
                        sh_r <= mem[adr_r];
                        sda_oe <= ~mem[adr_r][7];
                        adr_r <= adr_r + {{(AW-1){1'b0}}, 1'b1};
                    end else begin
                        // Every rising edge shifted the byte left, so bit 7 holds the next bit to send.
                        sda_oe <= ~sh_r[7];
                    end
                    sda_out <= 1'b0;
                end else begin
                    sda_oe <= 1'b0;
                end
            end
        end
    end

    // ======================================================================
    // Open-drain status pins: only ever pull low or release.
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            mod_abs_oe <= 1'b1;
            mod_abs_out <= 1'b0;
            module_not_ready_flag_oe <= 1'b0;
            module_not_ready_flag_out <= 1'b0;
            interrupt_oe <= 1'b0;
            interrupt_out <= 1'b0;
            receive_signal_lost_oe <= 1'b1;
            receive_signal_lost_out <= 1'b0;
        end else begin
            mod_abs_oe <= 1'b1;
            mod_abs_out <= 1'b0;
            module_not_ready_flag_out <= 1'b0;
            module_not_ready_flag_oe <= ready_r;
            interrupt_out <= 1'b0;
            interrupt_oe <= (|alarm_r) | (|warn_r) | ~los_s;
            receive_signal_lost_out <= 1'b0;
            receive_signal_lost_oe <= los_s;
        end
    end
endmodule

// >>> dv/omm_chk.sv
// Pin-level assertion checker for the management port.
`timescale 1ns/1ps
module omm_chk #(
    parameter int INIT_CYC = 16
) (
    input logic clock,
    input logic rst_b,
    input logic mod_desel,
    input logic laser_off_request,
    input logic power_down,
    input logic scl,
    input logic rx_light_ok,
    input logic [7:0] temp_adc,
    input logic sda_oe,
    input logic sda_out,
    input logic laser_enable,
    input logic low_power,
    input logic mod_abs_oe,
    input logic mod_abs_out,
    input logic module_not_ready_flag_oe,
    input logic module_not_ready_flag_out,
    input logic interrupt_oe,
    input logic interrupt_out,
    input logic receive_signal_lost_oe,
    input logic receive_signal_lost_out
);
    // ======
    // One clock domain; every check is dropped while reset is low.
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    property p_abs; mod_abs_oe && !mod_abs_out; endproperty
    a_abs: assert property (p_abs) else $error("absent pin not held low");
    property p_odrain;
        !sda_out && !interrupt_out && !module_not_ready_flag_out && !receive_signal_lost_out;
    endproperty
    a_odrain: assert property (p_odrain) else $error("pin driven high");
    property p_laser; $rose(laser_off_request) |-> ##[1:100] (!laser_enable || !laser_off_request); endproperty
    a_laser: assert property (p_laser) else $error("laser still lit");
    property p_desel; mod_desel [*8] |-> !sda_oe; endproperty
    a_desel: assert property (p_desel) else $error("data line held while deselected");
    property p_los; !rx_light_ok [*6] |-> interrupt_oe && !receive_signal_lost_oe; endproperty
    a_los: assert property (p_los) else $error("no interrupt on lost light");
    property p_irq; (temp_adc > 8'hF0) [*6] |-> interrupt_oe; endproperty
    a_irq: assert property (p_irq) else $error("no interrupt on alarm");
    property p_standby; power_down [*6] |-> low_power; endproperty
    a_standby: assert property (p_standby) else $error("standby not held");
    // The data line may only move while the serial clock was low two samples back.
    property p_rdedge; $changed(sda_oe) && !mod_desel |-> !$past(scl, 2); endproperty
    a_rdedge: assert property (p_rdedge) else $error("data moved in clock high");
    property p_ready;
        $fell(power_down) |-> ##[1:8] !module_not_ready_flag_oe ##[INIT_CYC:40] module_not_ready_flag_oe;
    endproperty
    a_ready: assert property (p_ready) else $error("ready sequence wrong");
endmodule
bind omm_mgmt_port omm_chk #(.INIT_CYC(INIT_CYC)) chk_i (.clock(clock), .rst_b(rst_b), .mod_desel(mod_desel),
    .laser_off_request(laser_off_request), .power_down(power_down), .scl(scl), .rx_light_ok(rx_light_ok),
    .temp_adc(temp_adc), .sda_oe(sda_oe), .sda_out(sda_out), .laser_enable(laser_enable), .low_power(low_power),
    .mod_abs_oe(mod_abs_oe), .mod_abs_out(mod_abs_out), .module_not_ready_flag_oe(module_not_ready_flag_oe),
    .module_not_ready_flag_out(module_not_ready_flag_out), .interrupt_oe(interrupt_oe),
    .interrupt_out(interrupt_out), .receive_signal_lost_oe(receive_signal_lost_oe),
    .receive_signal_lost_out(receive_signal_lost_out));

// >>> dv/omm_host_model.sv
// Host board two-wire bus master model.
`timescale 1ns/1ps
module omm_host_model (
    input logic clock,
    input logic sda_line,
    output logic scl,
    output logic sda_low
);
    // ======
    // Idle bus: clock parked high between frames, data released to the pull-up.
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // One bit of 8 clocks: data set early in the low phase, line read late in the high phase.
    task automatic bit_io(input logic b, output logic r);
        @(posedge clock) sda_low <= !b;
        repeat (4) @(posedge clock);
        scl <= 1'b1;
        repeat (2) @(posedge clock);
        r = sda_line;
        @(posedge clock) scl <= 1'b0;
    endtask
    // Start or repeated start; the clock stays low as long as in a data bit, so the module
    // has let go of its acknowledge before the clock rises and no stop is seen.
    task automatic start();
        @(posedge clock) sda_low <= 1'b0;
        repeat (4) @(posedge clock);
        scl <= 1'b1;
        repeat (4) @(posedge clock);
        sda_low <= 1'b1;
        repeat (4) @(posedge clock);
        scl <= 1'b0;
    endtask
    task automatic stop();
        @(posedge clock) sda_low <= 1'b1;
        repeat (4) @(posedge clock);
        scl <= 1'b1;
        repeat (4) @(posedge clock);
        sda_low <= 1'b0;
        repeat (4) @(posedge clock);
    endtask
    // Byte MSB first, then the acknowledge bit; ak is the line level seen.
    task automatic xbyte(input logic [7:0] d, input logic a, output logic [7:0] q, output logic ak);
        for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
        bit_io(a, ak);
    endtask
endmodule

// >>> dv/testbench.sv
// Self-checking bench for the optical module management port.
`timescale 1ns/1ps
`include "omm_defs.vh"
module testbench;
    logic clock = 1'b0, rst_b = 1'b0, mod_desel = 1'b1, laser_off_request = 1'b0;
    logic power_down = 1'b1, rx_light_ok = 1'b1;
    logic [7:0] temp_adc = 8'h40, bias_adc = 8'h41, txpwr_adc = 8'h42, rxpwr_adc = 8'h43, vcc_adc = 8'h44;
    logic scl, sda_low, sda_oe, sda_out, laser_enable, low_power, abs_oe, abs_out;
    logic nr_oe, nr_out, irq_oe, irq_out, los_oe, los_out, ak;
    logic [7:0] q;
    logic [31:0] v, w;
    int failures = 0, samples_checked = 0;
    // The line is low when either party pulls it, else the pull-up wins.
    wire sda_line = !(sda_low || sda_oe);
    omm_mgmt_port #(.INIT_CYC(4)) uut (.clock(clock), .rst_b(rst_b), .mod_desel(mod_desel),
        .laser_off_request(laser_off_request), .power_down(power_down), .scl(scl), .sda_in(sda_line),
        .sda_oe(sda_oe), .sda_out(sda_out), .rx_light_ok(rx_light_ok), .temp_adc(temp_adc), .bias_adc(bias_adc),
        .txpwr_adc(txpwr_adc), .rxpwr_adc(rxpwr_adc), .vcc_adc(vcc_adc), .laser_enable(laser_enable),
        .low_power(low_power), .mod_abs_oe(abs_oe), .mod_abs_out(abs_out), .module_not_ready_flag_oe(nr_oe),
        .module_not_ready_flag_out(nr_out), .interrupt_oe(irq_oe), .interrupt_out(irq_out),
        .receive_signal_lost_oe(los_oe), .receive_signal_lost_out(los_out));
    omm_host_model host (.clock(clock), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));
    // ======
    initial forever #50 clock = ~clock;
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic sendb(input logic [7:0] d);
        host.xbyte(d, 1'b1, q, ak);
        chk("ack", 32'(ak), 32'(1'b0));
    endtask
    task automatic wr(input logic [7:0] ptr, input logic [15:0] d);
        host.start();
        sendb({`OMM_DEV_ADDR, 1'b0});
        sendb(ptr);
        sendb(d[15:8]);
        sendb(d[7:0]);
        host.stop();
    endtask
    // Random read: pointer write, repeated start, n bytes with a final not-acknowledge.
    task automatic rd(input logic [7:0] ptr, input int n, output logic [31:0] r);
        host.start();
        sendb({`OMM_DEV_ADDR, 1'b0});
        sendb(ptr);
        host.start();
        sendb({`OMM_DEV_ADDR, 1'b1});
        for (int i = 0; i < n; i++) begin
            host.xbyte(8'hFF, i == n - 1, q, ak);
            r = {r[23:0], q};
        end
        host.stop();
    endtask
    // ======
    task automatic t_power();
        chk("pins", 32'({abs_oe, abs_out, low_power}), 32'(3'h5));
        @(posedge clock) power_down <= 1'b0;
        repeat (3) @(posedge clock);
        chk("not ready", 32'(nr_oe), 32'(1'b0));
        repeat (40) @(posedge clock);
        chk("ready", 32'({nr_oe, low_power}), 32'(2'h2));
        mod_desel <= 1'b0;
        repeat (8) @(posedge clock);
    endtask
    task automatic t_diag();
        rd(`OMM_LOC_TEMP, 4, v);
        chk("monitors", v, 32'h4041_4243);
        rd(`OMM_LOC_VCC, 4, v);
        chk("flags", v, 32'h4400_0000);
        @(posedge clock) temp_adc <= 8'h55;
        repeat (10) @(posedge clock);
        rd(`OMM_LOC_TEMP, 1, v);
        chk("refresh", v[7:0], 32'h55);
        rd(8'h7F, 1, w);
        wr(8'h7F, 16'hC33C);
        rd(8'h7F, 2, v);
        chk("boundary", v[15:0], {w[7:0], 8'h3C});
        wr(8'hFE, 16'h5AA5);
        rd(8'hFE, 2, v);
        chk("top", v[15:0], 32'h5AA5);
    endtask
    task automatic t_alarm();
        @(posedge clock) temp_adc <= 8'hF8;
        repeat (10) @(posedge clock);
        chk("irq hi", 32'(irq_oe), 32'(1'b1));
        rd(`OMM_LOC_ALARM, 2, v);
        chk("alarm warn", 32'({|v[15:8], |v[7:0]}), 32'(2'h3));
        @(posedge clock) temp_adc <= 8'h04;
        rd(`OMM_LOC_ALARM, 1, v);
        chk("alarm lo", 32'(|v[7:0]), 32'(1'b1));
        temp_adc <= 8'h40;
        rx_light_ok <= 1'b0;
        repeat (10) @(posedge clock);
        chk("lost", 32'({los_oe, irq_oe}), 32'(2'h1));
        rd(`OMM_LOC_STATUS, 1, v);
        chk("cause", 32'(v[2]), 32'(1'b1));
        rx_light_ok <= 1'b1;
        repeat (10) @(posedge clock);
        chk("clear", 32'({los_oe, irq_oe}), 32'(2'h2));
    endtask
    task automatic t_laser();
        @(posedge clock) laser_off_request <= 1'b1;
        for (int i = 0; i < `OMM_LASER_OFF_CYC && laser_enable; i++) @(posedge clock);
        chk("laser off", 32'(laser_enable), 32'(1'b0));
        laser_off_request <= 1'b0;
        repeat (100) @(posedge clock);
        chk("laser on", 32'(laser_enable), 32'(1'b1));
    endtask
    task automatic t_select();
        @(posedge clock) mod_desel <= 1'b1;
        repeat (8) @(posedge clock);
        host.start();
        host.xbyte({`OMM_DEV_ADDR, 1'b1}, 1'b1, q, ak);
        chk("desel ack", 32'(ak), 32'(1'b1));
        host.stop();
        mod_desel <= 1'b0;
        repeat (8) @(posedge clock);
        host.start();
        host.xbyte(8'h22, 1'b1, q, ak);
        chk("other addr", 32'(ak), 32'(1'b1));
        host.stop();
    endtask
    // Power-down pulse in mid-write must drop the transfer and restart initialisation.
    task automatic t_pdreset();
        wr(8'h90, 16'h1122);
        host.start();
        sendb({`OMM_DEV_ADDR, 1'b0});
        sendb(8'h90);
        @(posedge clock) power_down <= 1'b1;
        repeat (8) @(posedge clock);
        power_down <= 1'b0;
        repeat (3) @(posedge clock);
        chk("reinit", 32'(nr_oe), 32'(1'b0));
        host.xbyte(8'h77, 1'b1, q, ak);
        chk("dropped", 32'(ak), 32'(1'b1));
        host.stop();
        rd(8'h90, 1, v);
        chk("kept", v[7:0], 32'h11);
    endtask
    // ======
    initial begin
        repeat (6) @(posedge clock);
        rst_b <= 1'b1;
        t_power();
        t_diag();
        t_alarm();
        t_laser();
        t_select();
        t_pdreset();
        close_out();
    end
    // Whole run is near 0.55 ms of bus traffic; this limit cuts a hang short.
    initial begin
        #6000000;
        failures++;
        close_out();
    end
endmodule
